/* File: core/alt_boot_params.svh */
`ifndef ALT_BOOT_PARAMS_SVH
`define ALT_BOOT_PARAMS_SVH
`define CFG_ALT          2'h1
`define CFG_BSL          2'h2
`define CFG_NORMAL       2'h3
`define REG_INDICATOR    16'hFE0A
`define REG_SYSCFG       16'hFE12
`define REG_PERIPH       16'hF024
`define REG_BUSCFG       16'hFF0C
`define REG_MODE         16'hFE0C
`define ALT_FLAG_BIT     5
`define ROM_EN_BIT       10
`define BYTE_DIS_BIT     9
`define GLOBAL_PERIPHERAL_ENABLE_BIT         2
`define BUS_ACT_BIT      10
`define ALE_LEN_BIT      9
`define SYSCFG_ALT_RESET 16'h0404
`define SYSCFG_RESET     16'h0000
`define PERIPH_ALT_RESET 16'h002D
`define PERIPH_RESET     16'h0000
`define PERIPH_FLASH_BIT 2
`define ADDR_OP0_USER    24'h000000
`define ADDR_OP1_USER    24'h001FFC
`define ADDR_REF_USER    24'h001FFE
`define ADDR_OP0_ALT     24'h090000
`define ADDR_OP1_ALT     24'h091FFC
`define ADDR_REF_ALT     24'h091FFE
`define ADDR_ALT_START   24'h090000
`define ADDR_BSL_START   24'h000000
`define ADDR_LOOP        24'h000100
`define ADDR_USER_START  24'h000000
`define SEL_BOTH         8'h03
`define SEL_UART         8'h01
`define SEL_CAN          8'h02
`endif

/* File: core/alt_boot_pkg.sv */
package alt_boot_pkg;
   typedef enum logic [2:0] {MODE_NORMAL, MODE_BSL, MODE_ALT, MODE_TEST} boot_mode_e;
   typedef enum logic [3:0] {
      ST_IDLE, ST_RD_OP0, ST_RD_OP1, ST_RD_REF, ST_DECIDE, ST_RD_SEL, ST_DONE
   } seq_state_e;
endpackage

/* File: core/alternate_boot_select.sv */
// Added by the designer: the address-and-strobe port.
`include "alt_boot_params.svh"
module alternate_boot_select
   import alt_boot_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        RESET_N,
   input  wire logic        SOFT_RESET,
   input  wire logic        WATCHDOG_EXPIRED,
   input  wire logic [5:4]  RESET_CONFIG_PORT_LOW,
   input  wire logic        BUS_WIDTH_CFG,
   input  wire logic [1:0]  BUS_TYPE_CFG,
   input  wire logic        EXTERNAL_ACCESS_PIN,
   input  wire logic        END_OF_INIT_INSTRUCTION,
   input  wire logic        FETCH_REQ,
   input  wire logic [1:0]  FETCH_REGION,
   output logic             FETCH_ALLOWED,
   output logic [23:0]      FLASH_ADDR,
   output logic             FLASH_RD,
   input  wire logic [15:0] FLASH_DATA,
   input  wire logic        FLASH_VALID,
   input  wire logic [15:0] ADDR,
   input  wire logic [15:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic [15:0]      RDATA,
   output logic [23:0]      START_ADDR,
   output logic             START_VALID,
   output logic             UART_WATCH,
   output logic             CAN_WATCH,
   output logic             WATCHDOG_ENABLE,
   output logic             SOFT_RESET_REQ,
   output logic             CAN_PIN_OUTPUT_ALLOWED,
   output logic             TEST_MODE,
   output logic [1:0]       MODE_CODE
);
   // The configuration is captured in the first cycle after reset is released.
   logic             cap_done_reg;
   logic [1:0]       cfg_reg;
   logic             alt_flag_reg;
   boot_mode_e       mode_reg;
   seq_state_e       state_reg, state_next;
   logic [15:0]      syscfg_reg, periph_reg, buscfg_reg;
   logic [15:0]      op0_reg, ref_reg, sum_reg;
   logic             user_pass_reg, pass_alt_reg;
   logic             init_done_reg;
   logic [23:0]      flash_addr_next;
   logic             flash_rd_next;

   function automatic logic sig_ok(input logic [15:0] a, input logic [15:0] b, input logic [15:0] r);
      logic [15:0] s;
      s = a + b;
      return {s[15:8], ~s[7:0]} == r;
   endfunction

   wire boot_mode    = (mode_reg == MODE_BSL) || (mode_reg == MODE_ALT);
   wire soft_any     = SOFT_RESET || (WATCHDOG_EXPIRED && mode_reg == MODE_ALT);
   wire sys_wr       = WR && ADDR == `REG_SYSCFG && !init_done_reg;
   wire per_wr       = WR && ADDR == `REG_PERIPH && !init_done_reg;
   wire sel_zero     = FLASH_DATA == 16'h0000 || FLASH_DATA == 16'hFFFF;
   wire [15:0] sys_wmask = WDATA | (boot_mode ? 16'h0400 : 16'h0000);
   wire fetchable_flash_region_on    = syscfg_reg[`GLOBAL_PERIPHERAL_ENABLE_BIT] && periph_reg[`PERIPH_FLASH_BIT];
   wire [15:0] rd_mux =
      (ADDR == `REG_INDICATOR) ? {10'h000, alt_flag_reg, 5'h00} :
      (ADDR == `REG_SYSCFG)    ? syscfg_reg :
      (ADDR == `REG_PERIPH)    ? periph_reg :
      (ADDR == `REG_BUSCFG)    ? buscfg_reg :
      (ADDR == `REG_MODE)      ? {13'h0000, mode_reg} : 16'h0000;

   // Mode latch is cleared only by hardware reset so it stays stable.
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         cap_done_reg <= 1'b0;
         cfg_reg      <= 2'h0;
         mode_reg     <= MODE_NORMAL;
      end else if (!cap_done_reg) begin
         cap_done_reg <= 1'b1;
         cfg_reg      <= RESET_CONFIG_PORT_LOW;
         case (RESET_CONFIG_PORT_LOW)
            `CFG_ALT:    mode_reg <= MODE_ALT;
            `CFG_BSL:    mode_reg <= MODE_BSL;
            `CFG_NORMAL: mode_reg <= MODE_NORMAL;
            default:     mode_reg <= MODE_TEST;
         endcase
      end
   end

   // Flag and presets; software reset rebuilds them from the held configuration.
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         alt_flag_reg  <= 1'b0;
         syscfg_reg    <= `SYSCFG_RESET;
         periph_reg    <= `PERIPH_RESET;
         buscfg_reg    <= 16'h0000;
         init_done_reg <= 1'b0;
      end else if (!cap_done_reg || soft_any) begin
         alt_flag_reg  <= (cap_done_reg ? cfg_reg : RESET_CONFIG_PORT_LOW) == `CFG_ALT;
         init_done_reg <= 1'b0;
         if ((cap_done_reg ? cfg_reg : RESET_CONFIG_PORT_LOW) inside {`CFG_ALT, `CFG_BSL}) begin
            syscfg_reg <= {5'h00, 1'b1, BUS_WIDTH_CFG, 9'h000} |
                          ((cap_done_reg ? cfg_reg : RESET_CONFIG_PORT_LOW) == `CFG_ALT ?
                           `SYSCFG_ALT_RESET : `SYSCFG_RESET);
         end else begin
            syscfg_reg <= `SYSCFG_RESET;
         end
         periph_reg <= ((cap_done_reg ? cfg_reg : RESET_CONFIG_PORT_LOW) == `CFG_ALT) ?
                       `PERIPH_ALT_RESET : `PERIPH_RESET;
         buscfg_reg <= {5'h00, !EXTERNAL_ACCESS_PIN, !EXTERNAL_ACCESS_PIN, 1'b0,
                        BUS_TYPE_CFG, 6'h00};
      end else begin
         if (END_OF_INIT_INSTRUCTION)
            init_done_reg <= 1'b1;
         if (sys_wr)
            syscfg_reg <= sys_wmask;
         if (per_wr)
            periph_reg <= WDATA;
      end
   end

   always_comb begin
      state_next      = state_reg;
      flash_addr_next = FLASH_ADDR;
      flash_rd_next   = 1'b0;
      case (state_reg)
         ST_IDLE: if (cap_done_reg && mode_reg == MODE_ALT) begin
            state_next = ST_RD_OP0;
            flash_addr_next = `ADDR_OP0_USER;
            flash_rd_next = 1'b1;
         end
         ST_RD_OP0: if (FLASH_VALID) begin
            state_next = ST_RD_OP1;
            flash_addr_next = pass_alt_reg ? `ADDR_OP1_ALT : `ADDR_OP1_USER;
            flash_rd_next = 1'b1;
         end
         ST_RD_OP1: if (FLASH_VALID) begin
            state_next = ST_RD_REF;
            flash_addr_next = pass_alt_reg ? `ADDR_REF_ALT : `ADDR_REF_USER;
            flash_rd_next = 1'b1;
         end
         ST_RD_REF: if (FLASH_VALID)
            state_next = ST_DECIDE;
         ST_DECIDE: if (sig_ok(op0_reg, sum_reg, ref_reg) || pass_alt_reg) begin
            if (sig_ok(op0_reg, sum_reg, ref_reg))
               state_next = ST_DONE;
            else begin
               state_next = ST_RD_SEL;
               flash_addr_next = `ADDR_OP1_USER;
               flash_rd_next = 1'b1;
            end
         end else begin
            state_next = ST_RD_OP0;
            flash_addr_next = `ADDR_OP0_ALT;
            flash_rd_next = 1'b1;
         end
         ST_RD_SEL: if (FLASH_VALID)
            state_next = ST_DONE;
         ST_DONE: state_next = ST_DONE;
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RESET_N || soft_any) begin
         state_reg     <= ST_IDLE;
         FLASH_ADDR    <= 24'h000000;
         FLASH_RD      <= 1'b0;
         op0_reg       <= 16'h0000;
         sum_reg       <= 16'h0000;
         ref_reg       <= 16'h0000;
         pass_alt_reg  <= 1'b0;
         user_pass_reg <= 1'b0;
         START_ADDR    <= 24'h000000;
         START_VALID   <= 1'b0;
         UART_WATCH    <= 1'b0;
         CAN_WATCH     <= 1'b0;
      end else begin
         state_reg  <= state_next;
         FLASH_ADDR <= flash_addr_next;
         FLASH_RD   <= flash_rd_next;
         if (state_reg == ST_RD_OP0 && FLASH_VALID)
            op0_reg <= FLASH_DATA;
         if (state_reg == ST_RD_OP1 && FLASH_VALID)
            sum_reg <= FLASH_DATA;
         if (state_reg == ST_RD_REF && FLASH_VALID)
            ref_reg <= FLASH_DATA;
         if (state_reg == ST_DECIDE && !sig_ok(op0_reg, sum_reg, ref_reg))
            pass_alt_reg <= 1'b1;
         if (cap_done_reg && !START_VALID && mode_reg != MODE_ALT) begin
            START_VALID <= 1'b1;
            START_ADDR  <= (mode_reg == MODE_BSL) ? `ADDR_BSL_START : `ADDR_USER_START;
         end
         if (state_reg == ST_DECIDE && sig_ok(op0_reg, sum_reg, ref_reg)) begin
            START_VALID   <= 1'b1;
            user_pass_reg <= !pass_alt_reg;
            START_ADDR    <= pass_alt_reg ? `ADDR_ALT_START : `ADDR_USER_START;
         end
         if (state_reg == ST_RD_SEL && FLASH_VALID) begin
            START_VALID <= 1'b1;
            if (sel_zero)
               START_ADDR <= `ADDR_BSL_START;
            else begin
               case (FLASH_DATA[7:0])
                  `SEL_BOTH, `SEL_UART, `SEL_CAN: begin
                     START_ADDR <= `ADDR_BSL_START;
                     UART_WATCH <= FLASH_DATA[0];
                     CAN_WATCH  <= FLASH_DATA[1];
                  end
                  default: START_ADDR <= `ADDR_LOOP;
               endcase
            end
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         RDATA                  <= 16'h0000;
         FETCH_ALLOWED          <= 1'b0;
         WATCHDOG_ENABLE        <= 1'b0;
         SOFT_RESET_REQ         <= 1'b0;
         CAN_PIN_OUTPUT_ALLOWED <= 1'b0;
         TEST_MODE              <= 1'b0;
         MODE_CODE              <= 2'h0;
      end else begin
         RDATA                  <= RD ? rd_mux : 16'h0000;
         // Region 1 is data-only flash, region 2 the fetchable one.
         FETCH_ALLOWED          <= FETCH_REQ && (FETCH_REGION == 2'h2 ? fetchable_flash_region_on :
                                                 FETCH_REGION != 2'h1);
         WATCHDOG_ENABLE        <= cap_done_reg && mode_reg != MODE_ALT;
         SOFT_RESET_REQ         <= WATCHDOG_EXPIRED && mode_reg == MODE_ALT;
         CAN_PIN_OUTPUT_ALLOWED <= cap_done_reg && !boot_mode;
         TEST_MODE              <= mode_reg == MODE_TEST;
         MODE_CODE              <= cfg_reg;
      end
   end
endmodule // alternate_boot_select

/* File: verif/boot_flash_model.sv */
module boot_flash_model (
   input  wire logic        CLK,
   input  wire logic        SLOW,
   input  wire logic        FLASH_RD,
   input  wire logic [23:0] FLASH_ADDR,
   output logic [15:0]      FLASH_DATA,
   output logic             FLASH_VALID,
   output logic             CAN_RECEIVE_LINE
);
   timeunit 1ns;
   timeprecision 1ps;
   // The receive line is pulled up and stays recessive through every boot step.
   assign CAN_RECEIVE_LINE = 1'h1;
   logic [15:0] mem [logic [23:0]];
   logic [23:0] addr_reg;
   int          wait_reg = 0;
   initial FLASH_DATA = 16'h0000;
   initial FLASH_VALID = 1'h0;
   // Outside an answer the data lines toggle every cycle, so a stale word never holds for two cycles in a row.
   always @(posedge CLK) begin
      FLASH_VALID <= 1'h0;
      FLASH_DATA <= ~FLASH_DATA;
      if (FLASH_RD) begin
         addr_reg <= FLASH_ADDR;
         wait_reg <= SLOW ? 5 : 1;
      end else if (wait_reg > 0) begin
         wait_reg <= wait_reg - 1;
         if (wait_reg == 1) begin
            FLASH_VALID <= 1'h1;
            FLASH_DATA <= mem.exists(addr_reg) ? mem[addr_reg] : 16'hFFFF;
         end
      end
   end
endmodule // boot_flash_model

/* File: verif/alternate_boot_select_monitor.sv */
`include "alt_boot_params.svh"
module alternate_boot_select_monitor (
   input wire logic        CLK,
   input wire logic        RESET_N,
   input wire logic        WATCHDOG_EXPIRED,
   input wire logic        FETCH_REQ,
   input wire logic [1:0]  FETCH_REGION,
   input wire logic        FETCH_ALLOWED,
   input wire logic [15:0] ADDR,
   input wire logic        RD,
   input wire logic [15:0] RDATA,
   input wire logic        WATCHDOG_ENABLE,
   input wire logic        SOFT_RESET_REQ,
   input wire logic        CAN_PIN_OUTPUT_ALLOWED,
   input wire logic        TEST_MODE,
   input wire logic [1:0]  MODE_CODE
);
   logic [1:0] up_reg;
   always_ff @(posedge CLK) up_reg <= !RESET_N ? 2'h0 : up_reg + {1'h0, up_reg != 2'h3};
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   sequence s_dog;
      MODE_CODE == 2'h1 ##0 WATCHDOG_EXPIRED;
   endsequence
   a_mode_hold: assert property (up_reg == 2'h3 |-> $stable(MODE_CODE))
      else $error("mode code moved");
   a_test_decode: assert property (up_reg == 2'h3 |-> TEST_MODE == (MODE_CODE == 2'h0))
      else $error("test mode decode");
   a_dog_off: assert property (up_reg == 2'h3 && MODE_CODE == 2'h1 |-> !WATCHDOG_ENABLE)
      else $error("watchdog on");
   a_dog_soft: assert property (s_dog |=> SOFT_RESET_REQ)
      else $error("no soft reset");
   a_can_pin: assert property (up_reg == 2'h3 && MODE_CODE[0] != MODE_CODE[1] |-> !CAN_PIN_OUTPUT_ALLOWED)
      else $error("can pin output");
   a_flag_read: assert property (RD && ADDR == `REG_INDICATOR |=> RDATA[5] == (MODE_CODE == 2'h1))
      else $error("flag read");
   a_rdata_idle: assert property (!RD |=> RDATA == 16'h0000)
      else $error("read data idle");
   a_region_one: assert property (FETCH_REQ && FETCH_REGION == 2'h1 |=> !FETCH_ALLOWED)
      else $error("region one fetch");
endmodule // alternate_boot_select_monitor

/* File: verif/alternate_boot_select_bench.sv */
`include "alt_boot_params.svh"
module alternate_boot_select_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        CLK = 1'h0, RESET_N = 1'h0, SOFT_RESET = 1'h0, WATCHDOG_EXPIRED = 1'h0, SLOW = 1'h0;
   logic        BUS_WIDTH_CFG = 1'h1, EXTERNAL_ACCESS_PIN = 1'h1, END_OF_INIT_INSTRUCTION = 1'h0;
   logic        FETCH_REQ = 1'h0, WR = 1'h0, RD = 1'h0;
   logic [1:0]  RESET_CONFIG_PORT_LOW = 2'h0, BUS_TYPE_CFG = 2'h0, FETCH_REGION = 2'h0;
   logic [15:0] ADDR = 16'h0000, WDATA = 16'h0000, d, FLASH_DATA, RDATA;
   logic [23:0] FLASH_ADDR, START_ADDR;
   logic        FLASH_RD, FLASH_VALID, FETCH_ALLOWED, START_VALID, UART_WATCH, CAN_WATCH;
   logic        WATCHDOG_ENABLE, SOFT_RESET_REQ, CAN_PIN_OUTPUT_ALLOWED, TEST_MODE, CAN_RECEIVE_LINE;
   logic [1:0]  MODE_CODE;
   int          fails = 0, tests_run = 0;
   alternate_boot_select i_alternate_boot_select (.*);
   boot_flash_model i_boot_flash_model (.*);
   initial forever #2 CLK = ~CLK;
   task automatic cyc(int n = 1);
      repeat (n) @(posedge CLK);
   endtask
   task automatic check(string n, logic [23:0] seen, logic [23:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic put(logic [23:0] a, logic [15:0] v);
      i_boot_flash_model.mem[a] = v;
   endtask
   task automatic boot(logic [1:0] cfg, logic ea);
      RESET_N <= 1'h0;
      RESET_CONFIG_PORT_LOW <= cfg;
      EXTERNAL_ACCESS_PIN <= ea;
      cyc(3);
      RESET_N <= 1'h1;
      cyc(3);
   endtask
   task automatic rd(logic [15:0] a);
      ADDR <= a;
      RD <= 1'h1;
      cyc();
      RD <= 1'h0;
      #1 d = RDATA;
      cyc();
   endtask
   task automatic wr(logic [15:0] a, logic [15:0] v);
      ADDR <= a;
      WDATA <= v;
      WR <= 1'h1;
      cyc();
      WR <= 1'h0;
      cyc();
   endtask
   task automatic reg_is(string n, logic [15:0] a, logic [15:0] e);
      rd(a);
      check(n, d, e);
   endtask
   task automatic fetch(logic [1:0] r, logic e);
      FETCH_REGION <= r;
      FETCH_REQ <= 1'h1;
      cyc();
      FETCH_REQ <= 1'h0;
      #1 check("fetch", FETCH_ALLOWED, e);
      cyc();
   endtask
   task automatic wait_start(logic [23:0] st);
      int i;
      for (i = 0; i < 300 && START_VALID !== 1'h1; i++) cyc();
      if (i == 300) begin
         fails++;
         finish_test();
      end
      check("start", START_ADDR, st);
   endtask
   task automatic modes;
      for (int c = 0; c < 4; c++) begin
         boot(c[1:0], 1'h1);
         check("mode", MODE_CODE, c[1:0]);
         check("test", TEST_MODE, c == 0);
         check("dog", WATCHDOG_ENABLE, c != 1);
         if (c != 0) check("canpin", CAN_PIN_OUTPUT_ALLOWED, c == 3);
         rd(`REG_INDICATOR);
         check("flag", d[5], c == 1);
         reg_is("bus", `REG_BUSCFG, 16'h0000);
         wait_start(24'h000000);
      end
   endtask
   task automatic alt_user;
      put(24'h000000, 16'h1234);
      put(24'h001FFC, 16'h1111);
      put(24'h001FFE, 16'h23BA);
      BUS_TYPE_CFG <= 2'h2;
      boot(`CFG_ALT, 1'h0);
      wait_start(24'h000000);
      reg_is("sys", `REG_SYSCFG, 16'h0604);
      reg_is("periph", `REG_PERIPH, 16'h002D);
      reg_is("bus", `REG_BUSCFG, 16'h0680);
      wr(`REG_SYSCFG, 16'h0000);
      reg_is("sys", `REG_SYSCFG, 16'h0400);
      fetch(2'h2, 1'h0);
      wr(`REG_PERIPH, 16'h0005);
      wr(`REG_SYSCFG, 16'h0004);
      fetch(2'h2, 1'h1);
      fetch(2'h1, 1'h0);
      END_OF_INIT_INSTRUCTION <= 1'h1;
      cyc();
      END_OF_INIT_INSTRUCTION <= 1'h0;
      wr(`REG_PERIPH, 16'h0000);
      reg_is("periph", `REG_PERIPH, 16'h0005);
      wr(`REG_INDICATOR, 16'h0000);
      rd(`REG_INDICATOR);
      check("flag", d[5], 1'h1);
      reg_is("unmapped", 16'h0100, 16'h0000);
   endtask
   task automatic alt_alt;
      put(24'h001FFE, 16'h0000);
      put(24'h090000, 16'h00F0);
      put(24'h091FFC, 16'h0010);
      put(24'h091FFE, 16'h01FF);
      SLOW <= 1'h1;
      boot(`CFG_ALT, 1'h1);
      wait_start(24'h090000);
      WATCHDOG_EXPIRED <= 1'h1;
      cyc();
      WATCHDOG_EXPIRED <= 1'h0;
      #1 check("softreq", SOFT_RESET_REQ, 1'h1);
      cyc();
      SOFT_RESET <= 1'h1;
      cyc();
      SOFT_RESET <= 1'h0;
      cyc(3);
      check("mode", MODE_CODE, `CFG_ALT);
      wait_start(24'h090000);
   endtask
   task automatic selective;
      logic [15:0] s, sel [6] = '{16'h0000, 16'hFFFF, 16'hAB03, 16'hAB01, 16'hAB02, 16'hAB05};
      logic ok;
      i_boot_flash_model.mem.delete();
      put(24'h001FFE, 16'h5A5A);
      for (int i = 0; i < 6; i++) begin
         s = sel[i];
         ok = s != 16'h0000 && s != 16'hFFFF && s[7:0] inside {8'h01, 8'h02, 8'h03};
         put(24'h001FFC, s);
         SLOW <= i[0];
         boot(`CFG_ALT, 1'h1);
         wait_start(ok || i < 2 ? 24'h000000 : 24'h000100);
         check("uart", UART_WATCH, ok && s[0]);
         check("can", CAN_WATCH, ok && s[1]);
      end
   endtask
   initial begin
      cyc();
      modes();
      alt_user();
      alt_alt();
      selective();
      finish_test();
   end
endmodule // alternate_boot_select_bench
bind alternate_boot_select alternate_boot_select_monitor i_alternate_boot_select_monitor (.*);
